//--- hdl/cfem_pkg.sv
// Constants and types for the CAN acceptance-filter extended identifier
// and mask-source selection block.
// Assumes a single module clock and a plain one-cycle register port.
package cfem_pkg;

  localparam int unsigned NUM_FILTERS = 16;
  localparam int unsigned SEL_FILTERS = 8;
  localparam int unsigned ID_W        = 16;
  localparam int unsigned ADDR_W      = 5;

  // Register indices on the register port.
  localparam logic [ADDR_W-1:0] REG_EXT_ID_BASE = 5'h00;
  localparam logic [ADDR_W-1:0] REG_EXT_ID_LAST = 5'h0f;
  localparam logic [ADDR_W-1:0] REG_MASK_SEL    = 5'h10;
  localparam logic [ADDR_W-1:0] REG_MATCH_STAT  = 5'h11;

  // Values after reset, and the value read from an unmapped index.
  localparam logic [ID_W-1:0] EXT_ID_RESET   = 16'h0000;
  localparam logic [ID_W-1:0] MASK_SEL_RESET = 16'h0000;
  localparam logic [ID_W-1:0] MATCH_RESET    = 16'h0000;
  localparam logic [ID_W-1:0] RDATA_RESET    = 16'h0000;
  localparam logic [ID_W-1:0] UNMAPPED_READ  = 16'h0000;

  // Width of one mask-source field.
  localparam int unsigned SEL_W = 2;

  typedef enum logic [1:0] {
    SRC_MASK0 = 2'b00,
    SRC_MASK1 = 2'b01,
    SRC_MASK2 = 2'b10,
    SRC_RSVD  = 2'b11
  } cfem_mask_src_t;

endpackage

//--- hdl/cfem_mask_pick.sv
// Mask-source decoder for one filter: turns a 2-bit source field into
// the acceptance mask that applies to the filter.
// Assumes the three mask words come from mask registers outside.
`timescale 1ns/1ps
`default_nettype none
module cfem_mask_pick
  import cfem_pkg::*;
(
  input  wire logic [SEL_W-1:0] srcSel,    // Mask-source field
  input  wire logic [ID_W-1:0]  mask0,     // Acceptance mask 0
  input  wire logic [ID_W-1:0]  mask1,     // Acceptance mask 1
  input  wire logic [ID_W-1:0]  mask2,     // Acceptance mask 2
  output logic      [ID_W-1:0]  maskOut,   // Selected mask
  output logic                  reserved   // Field holds the reserved code
);

  // The reserved code selects no mask; the filter is then kept from
  // matching so that a bad setup rejects traffic rather than flooding.
  assign reserved = (srcSel == SRC_RSVD);
  assign maskOut  = (srcSel == SRC_MASK0) ? mask0 :
                    (srcSel == SRC_MASK1) ? mask1 :
                    (srcSel == SRC_MASK2) ? mask2 : '0;

endmodule
`default_nettype wire

//--- hdl/cfem_ext_match.sv
// Bitwise comparator of one filter's stored extended identifier bits
// against a received identifier, under the selected mask.
// Assumes inputs are stable registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cfem_ext_match
  import cfem_pkg::*;
(
  input  wire logic [ID_W-1:0] filterId,  // Stored filter identifier bits
  input  wire logic [ID_W-1:0] rxId,      // Received identifier bits
  input  wire logic [ID_W-1:0] mask,      // Selected acceptance mask
  input  wire logic            blocked,   // Reserved mask source in use
  output logic                 hit        // Filter accepts the identifier
);

  logic [ID_W-1:0] bitMiss;

  // A one must meet a one and a zero a zero, only where the mask is set.
  assign bitMiss = (filterId ^ rxId) & mask;
  assign hit     = !blocked && (bitMiss == '0);

endmodule
`default_nettype wire

//--- hdl/cfem_filter_top.sv
// Acceptance-filter extended identifier store and mask-source selection,
// with a register port and a per-filter match result.
// Assumes received identifiers, masks and the upper-filter selection come
// from logic on the same module clock.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Sixteen filters each have a writable and readable 16-bit extended identifier register.
// - Bits 15 to 0 of that register hold identifier bits 15 to 0 in the same positions.
// - A stored one matches only a received one at that position.
// - A stored zero matches only a received zero at that position.
// - One 16-bit selection register holds 2-bit mask-source fields, filter 7 on top, filter 0 at bottom.
// - Field value 00 picks mask 0, 01 picks mask 1 and 10 picks mask 2.
module cfem_filter_top
  import cfem_pkg::*;
(
  input  wire logic              clock,      // Module clock, 125 MHz
  input  wire logic              rst,        // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] regAddr,    // Register index
  input  wire logic [ID_W-1:0]   regWdata,   // Write data
  input  wire logic              regWr,      // Write strobe
  input  wire logic              regRd,      // Read strobe
  output logic      [ID_W-1:0]   regRdata,   // Read data, cycle after strobe
  input  wire logic [ID_W-1:0]   rxExtId,    // Received identifier bits 15-0
  input  wire logic              rxValid,    // Received identifier present
  input  wire logic [ID_W-1:0]   mask0,      // Acceptance mask 0 bits 15-0
  input  wire logic [ID_W-1:0]   mask1,      // Acceptance mask 1 bits 15-0
  input  wire logic [ID_W-1:0]   mask2,      // Acceptance mask 2 bits 15-0
  input  wire logic [ID_W-1:0]   selHigh,    // Mask sources of filters 15-8
  output logic      [ID_W-1:0]   matchVec,   // Per-filter hit, one per filter
  output logic                   matchValid  // matchVec is fresh this cycle
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and decode

  logic [ID_W-1:0] extId_q [NUM_FILTERS];
  logic [ID_W-1:0] maskSel_q;
  logic [ID_W-1:0] maskSel_d;
  logic [ID_W-1:0] lastMatch_q;
  logic [ID_W-1:0] rdata_q;
  logic [ID_W-1:0] rdata_d;
  logic [ID_W-1:0] match_q;
  logic [ID_W-1:0] match_d;
  logic            matchValid_q;

  wire  [3:0]      regIdx     = regAddr[3:0];
  wire             hitExtId   = (regAddr <= REG_EXT_ID_LAST);
  wire             hitMaskSel = (regAddr == REG_MASK_SEL);
  wire             hitStat    = (regAddr == REG_MATCH_STAT);
  wire             wrExtId    = regWr && hitExtId;
  wire             wrMaskSel  = regWr && hitMaskSel;

  assign maskSel_d = wrMaskSel ? regWdata : maskSel_q;

  // Readback mux; unmapped indices read as zero.
  assign rdata_d = !regRd     ? RDATA_RESET :
                   hitExtId   ? extId_q[regIdx] :
                   hitMaskSel ? maskSel_q :
                   hitStat    ? lastMatch_q : UNMAPPED_READ;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
        extId_q[i] <= EXT_ID_RESET;
      end
    end
    else if (wrExtId)
    begin
      extId_q[regIdx] <= regWdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      maskSel_q <= MASK_SEL_RESET;
      rdata_q   <= RDATA_RESET;
    end
    else
    begin
      maskSel_q <= maskSel_d;
      rdata_q   <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mask selection and comparison, one slice per filter

  logic [ID_W-1:0]        effMask [NUM_FILTERS];
  logic [NUM_FILTERS-1:0] rsvd;
  logic [NUM_FILTERS-1:0] hitNow;
  wire  [2*ID_W-1:0]      allSel = {selHigh, maskSel_q};

  generate
    for (genvar f = 0; f < NUM_FILTERS; f++)
    begin : g_filter
      cfem_mask_pick u_pick (
        .srcSel   (allSel[SEL_W*f +: SEL_W]),
        .mask0    (mask0),
        .mask1    (mask1),
        .mask2    (mask2),
        .maskOut  (effMask[f]),
        .reserved (rsvd[f])
      );
      cfem_ext_match u_match (
        .filterId (extId_q[f]),
        .rxId     (rxExtId),
        .mask     (effMask[f]),
        .blocked  (rsvd[f]),
        .hit      (hitNow[f])
      );
    end
  endgenerate

  // Result is held between identifiers so the datapath can sample it late.
  assign match_d = rxValid ? hitNow : match_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      match_q      <= MATCH_RESET;
      lastMatch_q  <= MATCH_RESET;
      matchValid_q <= 1'b0;
    end
    else
    begin
      match_q      <= match_d;
      lastMatch_q  <= match_d;
      matchValid_q <= rxValid;
    end
  end

  assign matchVec   = match_q;
  assign matchValid = matchValid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_write_id;
    regWr && hitExtId;
  endsequence

  sequence s_rx_f0;
    rxValid && !rsvd[0];
  endsequence

  sequence s_rx_any;
    rxValid;
  endsequence

  property p_id_store;
    logic [3:0] idx;
    logic [ID_W-1:0] val;
    @(posedge clock) disable iff (rst)
    (s_write_id, idx = regIdx, val = regWdata)
      ##1 (regRd && !regWr && regAddr == {1'b0, idx})
      |=> (regRdata == val);
  endproperty
  a_id_store: assert property (p_id_store)
    else $error("filter identifier readback differs from write");

  property p_id_bits;
    @(posedge clock) disable iff (rst)
    s_write_id |=> (extId_q[$past(regIdx)][15] == $past(regWdata[15]))
                   && (extId_q[$past(regIdx)][0] == $past(regWdata[0]));
  endproperty
  a_id_bits: assert property (p_id_bits)
    else $error("identifier bits not kept in place");

  property p_one_needs_one;
    @(posedge clock) disable iff (rst)
    (s_rx_f0 and ((effMask[0] & extId_q[0] & ~rxExtId) != '0)) |=> !matchVec[0];
  endproperty
  a_one_needs_one: assert property (p_one_needs_one)
    else $error("stored one matched a received zero");

  property p_zero_needs_zero;
    @(posedge clock) disable iff (rst)
    (s_rx_f0 and ((effMask[0] & ~extId_q[0] & rxExtId) != '0)) |=> !matchVec[0];
  endproperty
  a_zero_needs_zero: assert property (p_zero_needs_zero)
    else $error("stored zero matched a received one");

  property p_sel_layout;
    @(posedge clock) disable iff (rst)
    (regWr && hitMaskSel) |=> (maskSel_q == $past(regWdata))
                              && (g_filter[7].u_pick.srcSel == $past(regWdata[15:14]))
                              && (g_filter[0].u_pick.srcSel == $past(regWdata[1:0]));
  endproperty
  a_sel_layout: assert property (p_sel_layout)
    else $error("selection field landed in wrong bits");

  property p_mask_choice;
    @(posedge clock) disable iff (rst)
    ((maskSel_q[15:14] == SRC_MASK1) |-> (effMask[7] == mask1))
    and ((maskSel_q[1:0] == SRC_MASK2) |-> (effMask[0] == mask2))
    and ((maskSel_q[1:0] == SRC_MASK0) |-> (effMask[0] == mask0));
  endproperty
  a_mask_choice: assert property (p_mask_choice)
    else $error("wrong acceptance mask applied");

  property p_rsvd_rejects;
    @(posedge clock) disable iff (rst)
    (rxValid && maskSel_q[3:2] == SRC_RSVD) |=> !matchVec[1];
  endproperty
  a_rsvd_rejects: assert property (p_rsvd_rejects)
    else $error("reserved mask source produced a hit");

  property p_dont_care;
    @(posedge clock) disable iff (rst)
    (s_rx_f0 and (((extId_q[0] ^ rxExtId) & effMask[0]) == '0))
      |=> (matchVec[0] && matchValid) ##1 (matchVec[0] || $past(rxValid));
  endproperty
  a_dont_care: assert property (p_dont_care)
    else $error("unmasked difference stopped a hit");

  property p_upper_choice;
    @(posedge clock) disable iff (rst)
    ((selHigh[15:14] == SRC_MASK2) |-> (effMask[15] == mask2))
    and ((selHigh[1:0] == SRC_MASK1) |-> (effMask[8] == mask1));
  endproperty
  a_upper_choice: assert property (p_upper_choice)
    else $error("wrong acceptance mask applied to an upper filter");

  property p_zero_mask_hits;
    @(posedge clock) disable iff (rst)
    (rxValid && !rsvd[3] && (effMask[3] == '0)) |=> matchVec[3];
  endproperty
  a_zero_mask_hits: assert property (p_zero_mask_hits)
    else $error("empty mask did not give a hit");

  property p_id_isolated;
    @(posedge clock) disable iff (rst)
    (regWr && hitExtId && (regIdx != 4'h0)) |=> $stable(extId_q[0]);
  endproperty
  a_id_isolated: assert property (p_id_isolated)
    else $error("write to one filter disturbed filter 0");

  property p_valid_pulse;
    @(posedge clock) disable iff (rst)
    s_rx_any |=> matchValid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("match result not flagged after an identifier");

  property p_valid_once;
    @(posedge clock) disable iff (rst)
    !rxValid |=> !matchValid;
  endproperty
  a_valid_once: assert property (p_valid_once)
    else $error("match result flagged without an identifier");

  property p_vec_holds;
    @(posedge clock) disable iff (rst)
    !rxValid |=> $stable(matchVec);
  endproperty
  a_vec_holds: assert property (p_vec_holds)
    else $error("match vector changed between identifiers");

  property p_rdata_idle;
    @(posedge clock) disable iff (rst)
    !regRd |=> (regRdata == RDATA_RESET);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data shown without a read");

  property p_stat_view;
    @(posedge clock) disable iff (rst)
    (regRd && hitStat && !rxValid) |=> (regRdata == matchVec);
  endproperty
  a_stat_view: assert property (p_stat_view)
    else $error("match status read differs from match vector");

  property p_unmapped_read;
    @(posedge clock) disable iff (rst)
    (regRd && (regAddr > REG_MATCH_STAT)) |=> (regRdata == UNMAPPED_READ);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped index returned data");

  property p_reset_out;
    @(posedge clock)
    rst |=> (regRdata == RDATA_RESET) && (matchVec == MATCH_RESET) && !matchValid;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not cleared by reset");

endmodule
`default_nettype wire

//--- bench/cfem_rx_node.sv
// Receive-side node model: offers one identifier per request.
// Assumes the bench raises sendReq for one cycle per identifier.
`timescale 1ns/1ps
`default_nettype none
module cfem_rx_node
(
  input  wire logic        clock,    // Module clock
  input  wire logic        sendReq,  // Offer an identifier
  input  wire logic [15:0] sendId,   // Identifier to offer
  output logic      [15:0] rxExtId,  // Identifier to the filters
  output logic             rxValid   // Identifier present
);
  logic [15:0] lastQ = 16'h0000;

  always_ff @(posedge clock)
    if (sendReq)
      lastQ <= sendId;

  // Between frames the lines show the inverse, so stale data never matches.
  assign rxValid = sendReq;
  assign rxExtId = sendReq ? sendId : ~lastQ;
endmodule
`default_nettype wire

//--- bench/cfem_filter_top_tb_top.sv
// Self-checking bench for the filter identifier store and mask selection.
// Assumes a 125 MHz clock and the index map of the package.
`timescale 1ns/1ps
`default_nettype none
module cfem_filter_top_tb_top
  import cfem_pkg::*;
;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [ID_W-1:0]   regWdata = '0, mask0 = '0, mask1 = '0, mask2 = '0;
  logic [ID_W-1:0]   selHigh = '0, sendId = '0, selLow, ev, rx;
  logic              regWr = 1'b0, regRd = 1'b0, sendReq = 1'b0;
  logic [ID_W-1:0]   regRdata, rxExtId, matchVec;
  logic              rxValid, matchValid;
  logic [ID_W-1:0]   ids [NUM_FILTERS];
  int                err_total = 0, n_compared = 0, cyc = 0;

  always #4 clock = ~clock;

  cfem_filter_top uut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxExtId(rxExtId),
    .rxValid(rxValid), .mask0(mask0), .mask1(mask1), .mask2(mask2),
    .selHigh(selHigh), .matchVec(matchVec), .matchValid(matchValid));
  cfem_rx_node node (.clock(clock), .sendReq(sendReq), .sendId(sendId),
    .rxExtId(rxExtId), .rxValid(rxValid));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [ID_W-1:0] got, input logic [ID_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [ID_W-1:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [ID_W-1:0] exp);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    chk(regRdata, exp);
  endtask

  // Write and read back with no gap, so the read sees the fresh value.
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [ID_W-1:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    chk(regRdata, d);
  endtask

  // No reserved code
  // Software never writes the reserved code, so 11 is folded to 10.
  function automatic logic [ID_W-1:0] legal(input logic [ID_W-1:0] v);
    logic [ID_W-1:0] r;
    r = v;
    for (int f = 0; f < SEL_FILTERS; f++)
      if (r[2*f+:2] == 2'b11)
        r[2*f] = 1'b0;
    return r;
  endfunction

  function automatic logic [ID_W-1:0] expVec(input logic [ID_W-1:0] x);
    logic [ID_W-1:0] r, m;
    logic [1:0]      s;
    for (int f = 0; f < NUM_FILTERS; f++)
    begin
      s = (f < 8) ? selLow[2*f+:2] : selHigh[2*(f-8)+:2];
      m = (s == 2'b00) ? mask0 : (s == 2'b01) ? mask1 : mask2;
      r[f] = (s != 2'b11) && (((ids[f] ^ x) & m) == '0);
    end
    return r;
  endfunction

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(8754));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 18; k++)
      rd(k[4:0], 16'h0000);
    rd(5'h1f, UNMAPPED_READ);
    $display("test reset done");
    for (int k = 0; k < NUM_FILTERS; k++)
    begin
      ids[k] = 16'($urandom);
      wr_rd(k[4:0], ids[k]);
    end
    wr(5'h1f, 16'hffff);
    wr(REG_MATCH_STAT, 16'hffff);
    rd(REG_MATCH_STAT, 16'h0000);
    for (int k = 0; k < NUM_FILTERS; k++)
      rd(k[4:0], ids[k]);
    $display("test id store done");
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clock);
      selLow = legal(16'($urandom));
      selHigh <= legal(16'($urandom));
      mask0 <= 16'($urandom);
      mask1 <= 16'($urandom);
      mask2 <= 16'($urandom);
      rx = (k % 3 == 0) ? ids[$urandom % 16] : ids[$urandom % 16] ^ (16'h1 << (k % 16));
      if (k < 3)
      begin
        // Only the chosen mask is full, so a wrong pick changes the vector.
        selLow = {8{k[1:0]}};
        selHigh <= {8{k[1:0]}};
        mask0 <= (k == 0) ? 16'hffff : 16'h0000;
        mask1 <= (k == 1) ? 16'hffff : 16'h0000;
        mask2 <= (k == 2) ? 16'hffff : 16'h0000;
        rx = ids[5];
      end
      else if (k == 3)
      begin
        mask0 <= 16'h0000;
        mask1 <= 16'h0000;
        mask2 <= 16'h0000;
      end
      wr(REG_MASK_SEL, selLow);
      rd(REG_MASK_SEL, selLow);
      ev = expVec(rx);
      @(posedge clock);
      sendReq <= 1'b1;
      sendId <= rx;
      @(posedge clock);
      sendReq <= 1'b0;
      @(negedge clock);
      chk({15'h0000, matchValid}, 16'h0001);
      chk(matchVec, ev);
      @(negedge clock);
      chk({15'h0000, matchValid}, 16'h0000);
      rd(REG_MATCH_STAT, ev);
    end
    $display("test match done");
    close_out();
  end
endmodule
`default_nettype wire
